// file: psr_defines.svh
/*
 * Constants for the parallel/serial-in shift register: stage count, tap positions,
 * reset values and buffer sizing.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH

// ----------------------------------------
// register geometry
// ----------------------------------------
`define PSR_STAGES 8
`define PSR_TAP_LO 5
`define PSR_TAP_HI 7
`define PSR_TAP_W 3
`define PSR_STAGE_RST 8'h00
`define PSR_TAP_RST 3'h0

// ----------------------------------------
// buffering and timing
// ----------------------------------------
`define PSR_BUF_DEPTH 2
`define PSR_CLK_PERIOD_NS 40

`endif

// file: psr_pkg.sv
/*
 * Types shared by the shift register and its output buffer.
 * Assumes psr_defines.svh is on the include path.
 */
`include "psr_defines.svh"

package psr_pkg;
    // what a stage update does in the current cycle
    typedef enum logic [1:0] {
        PSR_HOLD,
        PSR_SHIFT,
        PSR_LOAD
    } psr_mode_t;

    typedef logic [`PSR_STAGES-1:0] psr_stages_t;
    typedef logic [`PSR_TAP_W-1:0] psr_taps_t;
endpackage

// file: psr_buf.sv
/*
 * Small shift-style FIFO; the head entry is a flip-flop driven straight out.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "psr_defines.svh"

module psr_buf
    import psr_pkg::*;
#(
    parameter int W = `PSR_TAP_W,
    parameter int DEPTH = `PSR_BUF_DEPTH
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // filling side
    input wire logic [W-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // draining side
    output logic [W-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] ONE_CNT = CW'(1);

    logic [W-1:0] entry_q [DEPTH];
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;
    logic [CW-1:0] wr_idx;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign wr_idx = pop ? count_q - ONE_CNT : count_q;
    assign count_d = count_q + (push ? ONE_CNT : '0) - (pop ? ONE_CNT : '0);

    // ----------------------------------------
    // storage: entries move one place toward the head on each pop
    // ----------------------------------------
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk_i) begin
            if (rst_i) begin
                entry_q[i] <= '0;
            end else if (push && wr_idx == CW'(i)) begin
                entry_q[i] <= in_data_i;
            end else if (pop) begin
                entry_q[i] <= (i + 1 < DEPTH) ? entry_q[(i + 1) % DEPTH] : entry_q[i];
            end
        end
    end

    // ----------------------------------------
    // occupancy and flags, all registered
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            count_q <= '0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            count_q <= count_d;
            in_ready_o <= count_d != FULL_CNT;
            out_valid_o <= count_d != '0;
        end
    end

    assign out_data_o = entry_q[0];
endmodule

// file: psr_top.sv
/*
 * Eight-stage shift register with serial or parallel entry and three buffered taps,
 * plus a buffered stream of the tap word after every update that finds room in the buffer.
 * Assumes every input is synchronous to core_clk_i and that the shift clock input
 * is slow enough to be seen low and high for at least one core cycle each.
 */
// Operation
// RULE_01: eight D stages share one shift clock and one load/shift select.
// RULE_02: stages change only on a rising edge of the shift clock.
// RULE_03: select low: stage one takes serial input, others take their predecessor.
// RULE_04: select high: every stage takes its own parallel input, serial ignored.
// RULE_05: stages six to eight are driven out; stages one to five stay internal.
// RULE_06: without a rising edge every stage holds regardless of other inputs.
`timescale 1ns/1ps
`include "psr_defines.svh"

module psr_top
    import psr_pkg::*;
#(
    parameter int STAGES = `PSR_STAGES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register controls
    input wire logic shift_clk_i,
    input wire logic sel_load_i,
    input wire logic serial_i,
    input wire logic [STAGES-1:0] stage_load_inputs_i,
    // buffered taps
    output logic [`PSR_TAP_W-1:0] late_stage_taps_o,
    // tap word stream
    output logic [`PSR_TAP_W-1:0] tap_word_o,
    output logic tap_valid_o,
    input wire logic tap_ready_i,
    output logic load_ready_o,
    output logic overrun_o
);
    // ----------------------------------------
    // edge detection on the shift clock
    // ----------------------------------------
    logic clk_prev_q;
    logic edge_rise;
    psr_mode_t mode;

    // reset high so a clock already high at release gives no false edge
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            clk_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= shift_clk_i;
        end
    end

    assign edge_rise = shift_clk_i && !clk_prev_q; // RULE_02

    always_comb begin
        if (!edge_rise) begin
            mode = PSR_HOLD; // RULE_06
        end else if (sel_load_i) begin
            mode = PSR_LOAD;
        end else begin
            mode = PSR_SHIFT;
        end
    end

    // ----------------------------------------
    // stages
    // ----------------------------------------
    logic [STAGES-1:0] stage_q;
    logic [STAGES-1:0] stage_d;
    logic first_stage_state;

    assign first_stage_state = stage_q[0];

    // one select steers all eight stages alike
    for (genvar i = 0; i < STAGES; i++) begin : g_stage
        // stage one has no predecessor, so it takes the serial input instead
        logic from_prev;
        logic bit_d;

        assign from_prev = (i == 0) ? serial_i : stage_q[(i + STAGES - 1) % STAGES];

        // each bit has its own process so no two processes write one variable
        always_comb begin
            case (mode)
                PSR_LOAD: bit_d = stage_load_inputs_i[i]; // RULE_04
                PSR_SHIFT: bit_d = from_prev; // RULE_03
                PSR_HOLD: bit_d = stage_q[i]; // RULE_06
                default: bit_d = stage_q[i];
            endcase
        end

        assign stage_d[i] = bit_d;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage_q <= `PSR_STAGE_RST;
        end else begin
            stage_q <= stage_d; // RULE_01
        end
    end

    // taps take the next value so they track the stages without a cycle of lag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            late_stage_taps_o <= `PSR_TAP_RST;
        end else begin
            late_stage_taps_o <= stage_d[`PSR_TAP_HI:`PSR_TAP_LO]; // RULE_05
        end
    end

    // ----------------------------------------
    // tap word stream
    // ----------------------------------------
    logic push_q;
    logic [`PSR_TAP_W-1:0] push_word_q;
    logic buf_in_ready;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            push_q <= 1'b0;
            push_word_q <= `PSR_TAP_RST;
        end else begin
            push_q <= edge_rise;
            push_word_q <= stage_d[`PSR_TAP_HI:`PSR_TAP_LO];
        end
    end

    // the register never waits; a controller that clocks while not ready loses a word
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            overrun_o <= 1'b0;
        end else if (push_q && !buf_in_ready) begin
            overrun_o <= 1'b1;
        end
    end

    // ready is registered so the controller sees it one cycle behind the buffer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            load_ready_o <= 1'b0;
        end else begin
            load_ready_o <= buf_in_ready && !push_q && !edge_rise;
        end
    end

    psr_buf #(
        .W(`PSR_TAP_W),
        .DEPTH(`PSR_BUF_DEPTH)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_data_i(push_word_q),
        .in_valid_i(push_q),
        .in_ready_o(buf_in_ready),
        .out_data_o(tap_word_o),
        .out_valid_o(tap_valid_o),
        .out_ready_i(tap_ready_i)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_common_update;
        @(posedge core_clk_i) disable iff (rst_i)
        edge_rise |=> stage_q == ($past(sel_load_i) ? $past(stage_load_inputs_i)
                                  : {$past(stage_q[STAGES-2:0]), $past(serial_i)});
    endproperty
    a_common_update: assert property (p_common_update) // RULE_01
        else $error("stage update does not follow the common select");

    property p_edge_only;
        @(posedge core_clk_i) disable iff (rst_i)
        ($changed(stage_q) && !$past(rst_i)) |-> $past(shift_clk_i) && !$past(clk_prev_q);
    endproperty
    a_edge_only: assert property (p_edge_only) // RULE_02
        else $error("stages changed without a rising shift clock edge");

    property p_shift;
        @(posedge core_clk_i) disable iff (rst_i)
        (edge_rise && !sel_load_i) |=> first_stage_state == $past(serial_i)
            && stage_q[STAGES-1:1] == $past(stage_q[STAGES-2:0]);
    endproperty
    a_shift: assert property (p_shift) // RULE_03
        else $error("serial shift moved the wrong data");

    property p_load;
        @(posedge core_clk_i) disable iff (rst_i)
        (edge_rise && sel_load_i) |=> stage_q == $past(stage_load_inputs_i);
    endproperty
    a_load: assert property (p_load) // RULE_04
        else $error("parallel load did not capture the load inputs");

    property p_taps;
        @(posedge core_clk_i) disable iff (rst_i)
        ##1 late_stage_taps_o == stage_q[`PSR_TAP_HI:`PSR_TAP_LO];
    endproperty
    a_taps: assert property (p_taps) // RULE_05
        else $error("taps do not show stages six to eight");

    property p_hold;
        @(posedge core_clk_i) disable iff (rst_i)
        (!edge_rise ##1 !edge_rise) |=> $stable(stage_q) && $stable(late_stage_taps_o);
    endproperty
    a_hold: assert property (p_hold) // RULE_06
        else $error("stages moved while no edge was seen");

    property p_stream;
        @(posedge core_clk_i) disable iff (rst_i)
        (edge_rise && buf_in_ready) |=> ##[1:2] tap_valid_o;
    endproperty
    a_stream: assert property (p_stream)
        else $error("accepted update never reached the stream");

    property p_ready_gap;
        @(posedge core_clk_i) disable iff (rst_i)
        edge_rise |=> !load_ready_o ##1 !load_ready_o;
    endproperty
    a_ready_gap: assert property (p_ready_gap)
        else $error("load ready shown too soon after an update");

    property p_overrun_set;
        @(posedge core_clk_i) disable iff (rst_i)
        (push_q && !buf_in_ready) |=> overrun_o;
    endproperty
    a_overrun_set: assert property (p_overrun_set)
        else $error("dropped tap word did not flag an overrun");

    property p_overrun_sticky;
        @(posedge core_clk_i) disable iff (rst_i)
        overrun_o |=> overrun_o;
    endproperty
    a_overrun_sticky: assert property (p_overrun_sticky)
        else $error("overrun flag cleared without reset");
endmodule

// file: psr_ctl.sv
/*
 * Controller model: makes one shift-clock pulse per bench request.
 * Assumes requests arrive between core clock edges and one clock domain.
 */
`timescale 1ns/1ps

module psr_ctl (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // bench request
    input wire logic go_i,
    input wire logic force_i,
    input wire logic sel_i,
    input wire logic bit_i,
    input wire logic [7:0] word_i,
    output logic busy_o,
    // device side
    input wire logic load_ready_i,
    output logic shift_clk_o,
    output logic sel_load_o,
    output logic serial_o,
    output logic [7:0] stage_load_inputs_o
);
    logic [1:0] st_q;

    initial begin
        st_q = 2'h0;
        busy_o = 1'b0;
        shift_clk_o = 1'b0;
        sel_load_o = 1'b0;
        serial_o = 1'b0;
        stage_load_inputs_o = 8'h00;
    end

    // ----------------------------------------
    // one pulse: high for one core cycle, then low
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q <= 2'h0;
            busy_o <= 1'b0;
            shift_clk_o <= 1'b0;
        end else begin
            case (st_q)
                2'h0: if (go_i) begin
                    st_q <= 2'h1;
                    busy_o <= 1'b1;
                end
                // force breaks flow control on purpose to provoke an overrun
                2'h1: if (load_ready_i || force_i) begin
                    shift_clk_o <= 1'b1;
                    sel_load_o <= sel_i;
                    serial_o <= bit_i;
                    stage_load_inputs_o <= word_i;
                    st_q <= 2'h2;
                end
                default: begin
                    // hold time is zero, so stale data is not left on the lines
                    shift_clk_o <= 1'b0;
                    sel_load_o <= ~sel_load_o;
                    serial_o <= ~serial_o;
                    stage_load_inputs_o <= ~stage_load_inputs_o;
                    st_q <= 2'h0;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

// file: tb_psr_top.sv
/*
 * Self-checking bench for the shift register and its tap stream.
 * Assumes psr_ctl as the controller and one 25 MHz clock.
 */
`timescale 1ns/1ps

module tb_psr_top;
    import psr_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic go = 1'b0, frc = 1'b0, sel = 1'b0, sbit = 1'b0, rdy = 1'b1, busy;
    logic [7:0] word = 8'h00;
    logic shclk, sell, ser, lrdy, tval, ovr;
    logic [7:0] pin;
    psr_taps_t taps, tword, w1;
    psr_stages_t exp;
    int errors = 0, compares = 0;

    always #20 core_clk_i = ~core_clk_i;

    psr_ctl u_ctl (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .force_i(frc),
        .sel_i(sel), .bit_i(sbit), .word_i(word), .busy_o(busy), .load_ready_i(lrdy),
        .shift_clk_o(shclk), .sel_load_o(sell), .serial_o(ser), .stage_load_inputs_o(pin));
    psr_top DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .shift_clk_i(shclk),
        .sel_load_i(sell), .serial_i(ser), .stage_load_inputs_i(pin),
        .late_stage_taps_o(taps), .tap_word_o(tword), .tap_valid_o(tval),
        .tap_ready_i(rdy), .load_ready_o(lrdy), .overrun_o(ovr));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, want, seen);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one shift-clock edge through the controller, model updated alongside
    task automatic op(input logic m, input logic b, input logic [7:0] w);
        int n;
        @(negedge core_clk_i);
        sel = m;
        sbit = b;
        word = w;
        go = 1'b1;
        @(negedge core_clk_i);
        go = 1'b0;
        for (n = 0; busy !== 1'b0; n++) begin
            if (n == 20) begin
                errors++;
                end_of_test();
            end
            @(negedge core_clk_i);
        end
        exp = m ? w : {exp[6:0], b};
        chk("taps", {5'h00, taps}, {5'h00, exp[7:5]});
    endtask

    task automatic t_load();
        op(1'b1, 1'b0, 8'ha5);
        op(1'b1, 1'b1, 8'h5a);
        op(1'b1, 1'b1, 8'h00);
    endtask

    task automatic t_shift();
        int i;
        for (i = 0; i < 8; i++) op(1'b0, i[0] ^ i[2], 8'hff);
        for (i = 0; i < 5; i++) op(1'b0, 1'b0, 8'hff);
    endtask

    task automatic t_hold();
        psr_taps_t t0;
        t0 = taps;
        repeat (30) begin
            @(negedge core_clk_i);
            chk("hold", {5'h00, taps}, {5'h00, t0});
        end
    endtask

    task automatic t_stream();
        rdy = 1'b0;
        op(1'b1, 1'b0, 8'h20);
        w1 = exp[7:5];
        op(1'b1, 1'b0, 8'hc0);
        repeat (3) @(negedge core_clk_i);
        chk("full", {6'h00, tval, lrdy}, 8'h02);
        chk("head", {5'h00, tword}, {5'h00, w1});
        rdy = 1'b1;
        @(negedge core_clk_i);
        chk("next", {5'h00, tword}, {5'h00, exp[7:5]});
        @(negedge core_clk_i);
        chk("empty", {7'h00, tval}, 8'h00);
        rdy = 1'b0;
        frc = 1'b1;
        repeat (3) op(1'b0, 1'b1, 8'h00);
        frc = 1'b0;
        repeat (3) @(negedge core_clk_i);
        chk("overrun", {7'h00, ovr}, 8'h01);
        rdy = 1'b1;
    endtask

    initial begin
        exp = 8'h00;
        repeat (12) @(negedge core_clk_i);
        rst_i = 1'b0;
        chk("rst", {3'h0, taps, tval, ovr}, 8'h00);
        repeat (3) @(negedge core_clk_i);
        t_load();
        t_hold();
        t_shift();
        t_hold();
        t_stream();
        end_of_test();
    end
endmodule
